// *** hdl/frtc_cfg.svh ***
`ifndef FRTC_CFG_SVH
`define FRTC_CFG_SVH

// =========================================
// Register addresses (byte offsets in the timer window)
`define FRTC_ADR_IER 4'h0
`define FRTC_ADR_CSR 4'h1
`define FRTC_ADR_CNT_H 4'h2
`define FRTC_ADR_CNT_L 4'h3
`define FRTC_ADR_CMP_H 4'h4
`define FRTC_ADR_CMP_L 4'h5
`define FRTC_ADR_CKE 4'h6
`define FRTC_ADR_OCR 4'h7
`define FRTC_ADR_CAP_H 4'h8
`define FRTC_ADR_CAP_L 4'h9

// =========================================
// Field positions
`define FRTC_BIT_CAPF 7
`define FRTC_BIT_MAF 3
`define FRTC_BIT_MBF 2
`define FRTC_BIT_WRAPF 1
`define FRTC_BIT_CLRA 0
`define FRTC_BIT_EDGE 7
`define FRTC_BIT_OSEL 4
`define FRTC_BIT_LVLA 1
`define FRTC_BIT_LVLB 0

// =========================================
// Reset values and fixed bits
`define FRTC_RST_CSR 8'h00
`define FRTC_RST_CKE 8'h00
`define FRTC_RST_OCR 8'he0
`define FRTC_RST_IER 8'h01
`define FRTC_RST_CMP 16'hffff
`define FRTC_OCR_ONES 8'he0
`define FRTC_OCR_WMASK 8'h13
`define FRTC_IER_WMASK 8'h8e
`define FRTC_CSR_FLAGS 8'h8e

// =========================================
// Timing
`define FRTC_DIV8 8
`define FRTC_DIV32 32
`define FRTC_DIV128 128
`endif

// *** hdl/frtc_pkg.sv ***
package frtc_pkg;
  // Bus request toward the register block
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } frtc_req_s;

  // Counter clock source encoding
  typedef enum logic [1:0] {
    FRTC_CK_DIV8 = 2'b00,
    FRTC_CK_DIV32 = 2'b01,
    FRTC_CK_DIV128 = 2'b10,
    FRTC_CK_EXT = 2'b11
  } frtc_cks_e;
endpackage

// *** hdl/frtc_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser; a change is taken once stages two and three agree
module frtc_sync (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic din, // Asynchronous pin
  output logic level, // Filtered level
  output logic rise, // One-cycle rising pulse
  output logic fall // One-cycle falling pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // =========================================
  // Shift chain; s1 feeds only s2
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept the new level only when the last two stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level = lvl_q;
  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule

// *** hdl/frtc_prescale.sv ***
`timescale 1ns/1ns
`include "frtc_cfg.svh"
// Prescaler giving one-cycle ticks at clk/8, /32 and /128
module frtc_prescale (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic stby, // Standby holds divider at zero
  output logic tick8, // Tick every 8 clocks
  output logic tick32, // Tick every 32 clocks
  output logic tick128 // Tick every 128 clocks
);
  logic [6:0] div_q;

  // =========================================
  // Free divider, reset by standby so ticks are repeatable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 7'h00;
    end else if (stby) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  assign tick8 = (div_q[2:0] == 3'(`FRTC_DIV8 - 1));
  assign tick32 = (div_q[4:0] == 5'(`FRTC_DIV32 - 1));
  assign tick128 = (div_q == 7'(`FRTC_DIV128 - 1));
endmodule

// *** hdl/frtc_top.sv ***
`timescale 1ns/1ns
`include "frtc_cfg.svh"
// Free-running timer: counter, compare, capture and control registers
module frtc_top (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset, // Async reset, high
  input wire logic stby, // Standby or module standby, high
  input wire frtc_pkg::frtc_req_s req, // Byte register request
  output logic [7:0] rdata, // Read data, valid same cycle as rd
  input wire logic capture_input_pin, // Capture input pin
  input wire logic ext_clk_pin, // External count clock pin
  output logic compare_output_pin_a, // Compare output A
  output logic compare_output_pin_b, // Compare output B
  output logic irq_capture, // Capture request, level
  output logic irq_match_a, // Match A request, level
  output logic irq_match_b, // Match B request, level
  output logic irq_wrap // Wrap request, level
);
  logic [7:0] csr_q;
  logic [7:0] cke_q;
  logic [7:0] ocr_q;
  logic [7:0] ier_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpb_q;
  logic [15:0] cap_q;
  logic [7:0] temp_q;
  logic [7:0] seen_q;
  logic pin_a_q;
  logic pin_b_q;
  logic tick8;
  logic tick32;
  logic tick128;
  logic cap_rise;
  logic cap_fall;
  logic ext_rise;
  logic tick;
  logic cap_evt;
  logic match_a;
  logic match_b;
  logic wrap;
  logic cnt_wr;
  logic cmp_wr;
  logic wr_csr;
  logic rd_csr;
  frtc_pkg::frtc_cks_e cks;

  // =========================================
  // Support blocks
  frtc_prescale u_pre (
    .clk(clk),
    .reset(reset),
    .stby(stby),
    .tick8(tick8),
    .tick32(tick32),
    .tick128(tick128)
  );

  frtc_sync u_cap_sync (
    .clk(clk),
    .reset(reset),
    .din(capture_input_pin),
    .level(),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  frtc_sync u_ext_sync (
    .clk(clk),
    .reset(reset),
    .din(ext_clk_pin),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  // =========================================
  // Event decode
  assign cks = frtc_pkg::frtc_cks_e'(cke_q[1:0]);
  always_comb begin
    case (cks)
      frtc_pkg::FRTC_CK_DIV8: tick = tick8;
      frtc_pkg::FRTC_CK_DIV32: tick = tick32;
      frtc_pkg::FRTC_CK_DIV128: tick = tick128;
      frtc_pkg::FRTC_CK_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  assign cap_evt = cke_q[`FRTC_BIT_EDGE] ? cap_rise : cap_fall;
  assign cnt_wr = req.wr && (req.addr == `FRTC_ADR_CNT_L);
  assign cmp_wr = req.wr && (req.addr == `FRTC_ADR_CMP_L);
  // Match fires on the tick that leaves the matching value; a write to the
  // compare low byte in that cycle suppresses it only for the channel that OSEL selects
  assign match_a = tick && (cnt_q == cmpa_q) && !(cmp_wr && !ocr_q[`FRTC_BIT_OSEL]);
  assign match_b = tick && (cnt_q == cmpb_q) && !(cmp_wr && ocr_q[`FRTC_BIT_OSEL]);
  assign wrap = tick && (cnt_q == 16'hffff) && !cnt_wr
    && !(match_a && csr_q[`FRTC_BIT_CLRA]);
  assign wr_csr = req.wr && (req.addr == `FRTC_ADR_CSR);
  assign rd_csr = req.rd && (req.addr == `FRTC_ADR_CSR);

  // =========================================
  // Counter: clear beats write, write beats increment
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
    end else if (stby) begin
      cnt_q <= 16'h0000;
    end else if (match_a && csr_q[`FRTC_BIT_CLRA]) begin
      cnt_q <= 16'h0000;
    end else if (cnt_wr) begin
      cnt_q <= {temp_q, req.wdata};
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Compare registers behind the shared address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmpa_q <= `FRTC_RST_CMP;
      cmpb_q <= `FRTC_RST_CMP;
    end else if (stby) begin
      cmpa_q <= `FRTC_RST_CMP;
      cmpb_q <= `FRTC_RST_CMP;
    end else if (cmp_wr && !ocr_q[`FRTC_BIT_OSEL]) begin
      cmpa_q <= {temp_q, req.wdata};
    end else if (cmp_wr) begin
      cmpb_q <= {temp_q, req.wdata};
    end
  end

  // Capture register; a capture in the cycle of a high-byte read waits one cycle
  logic cap_pend_q;
  logic cap_rd_h;
  assign cap_rd_h = req.rd && (req.addr == `FRTC_ADR_CAP_H);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_q <= 16'h0000;
      cap_pend_q <= 1'b0;
    end else if (stby) begin
      cap_q <= 16'h0000;
      cap_pend_q <= 1'b0;
    end else if ((cap_evt || cap_pend_q) && cap_rd_h) begin
      cap_pend_q <= 1'b1;
    end else if (cap_evt || cap_pend_q) begin
      cap_q <= cnt_q;
      cap_pend_q <= 1'b0;
    end
  end

  // =========================================
  // Flag register; set beats clear in the same cycle
  logic [7:0] set_v;
  logic [7:0] clr_v;
  always_comb begin
    set_v = 8'h00;
    set_v[`FRTC_BIT_CAPF] = (cap_evt || cap_pend_q) && !cap_rd_h;
    set_v[`FRTC_BIT_MAF] = match_a;
    set_v[`FRTC_BIT_MBF] = match_b;
    set_v[`FRTC_BIT_WRAPF] = wrap;
    // Clear only bits written zero that were seen set by a prior read
    clr_v = wr_csr ? (~req.wdata & seen_q & `FRTC_CSR_FLAGS) : 8'h00;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      csr_q <= `FRTC_RST_CSR;
    end else if (stby) begin
      csr_q <= `FRTC_RST_CSR;
    end else begin
      csr_q[7:1] <= ((csr_q[7:1] & ~clr_v[7:1]) | set_v[7:1]) & 7'h47;
      if (wr_csr) begin
        csr_q[`FRTC_BIT_CLRA] <= req.wdata[`FRTC_BIT_CLRA];
      end
    end
  end

  // Flags observed at one by a read; consumed by the next write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen_q <= 8'h00;
    end else if (stby) begin
      seen_q <= 8'h00;
    end else if (rd_csr) begin
      seen_q <= csr_q & `FRTC_CSR_FLAGS;
    end else if (wr_csr) begin
      seen_q <= 8'h00;
    end
  end

  // =========================================
  // Control, output control and enable registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cke_q <= `FRTC_RST_CKE;
      ocr_q <= `FRTC_RST_OCR;
      ier_q <= `FRTC_RST_IER;
    end else if (stby) begin
      cke_q <= `FRTC_RST_CKE;
      ocr_q <= `FRTC_RST_OCR;
      ier_q <= `FRTC_RST_IER;
    end else if (req.wr) begin
      if (req.addr == `FRTC_ADR_CKE) begin
        cke_q <= req.wdata;
      end
      if (req.addr == `FRTC_ADR_OCR) begin
        ocr_q <= (req.wdata & `FRTC_OCR_WMASK) | `FRTC_OCR_ONES;
      end
      if (req.addr == `FRTC_ADR_IER) begin
        ier_q <= (req.wdata & `FRTC_IER_WMASK) | `FRTC_RST_IER;
      end
    end
  end

  // Byte pairing: high write or counter/capture high read loads the temp byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temp_q <= 8'h00;
    end else if (req.wr && (req.addr == `FRTC_ADR_CNT_H || req.addr == `FRTC_ADR_CMP_H)) begin
      temp_q <= req.wdata;
    end else if (req.rd && req.addr == `FRTC_ADR_CNT_H) begin
      temp_q <= cnt_q[7:0];
    end else if (cap_rd_h) begin
      temp_q <= cap_q[7:0];
    end
  end

  // =========================================
  // Output pins hold until the next match of their channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      if (match_a) begin
        pin_a_q <= ocr_q[`FRTC_BIT_LVLA];
      end
      if (match_b) begin
        pin_b_q <= ocr_q[`FRTC_BIT_LVLB];
      end
    end
  end

  assign compare_output_pin_a = pin_a_q;
  assign compare_output_pin_b = pin_b_q;
  assign irq_capture = csr_q[`FRTC_BIT_CAPF] && ier_q[7];
  assign irq_match_a = csr_q[`FRTC_BIT_MAF] && ier_q[3];
  assign irq_match_b = csr_q[`FRTC_BIT_MBF] && ier_q[2];
  assign irq_wrap = csr_q[`FRTC_BIT_WRAPF] && ier_q[1];

  // =========================================
  // Read mux; unmapped addresses return zero
  always_comb begin
    case (req.addr)
      `FRTC_ADR_IER: rdata = ier_q;
      `FRTC_ADR_CSR: rdata = csr_q;
      `FRTC_ADR_CNT_H: rdata = cnt_q[15:8];
      `FRTC_ADR_CNT_L: rdata = temp_q;
      `FRTC_ADR_CMP_H: rdata = ocr_q[`FRTC_BIT_OSEL] ? cmpb_q[15:8] : cmpa_q[15:8];
      `FRTC_ADR_CMP_L: rdata = ocr_q[`FRTC_BIT_OSEL] ? cmpb_q[7:0] : cmpa_q[7:0];
      `FRTC_ADR_CKE: rdata = cke_q;
      `FRTC_ADR_OCR: rdata = ocr_q;
      `FRTC_ADR_CAP_H: rdata = cap_q[15:8];
      `FRTC_ADR_CAP_L: rdata = temp_q;
      default: rdata = 8'h00;
    endcase
  end

  // =========================================
  // Checks
  sequence s_seen_a;
    rd_csr && csr_q[`FRTC_BIT_MAF];
  endsequence

  a_flag_sw_set: assert property (@(posedge clk) disable iff (reset)
    (!csr_q[`FRTC_BIT_CAPF] && !cap_evt && !cap_pend_q) |=> !csr_q[`FRTC_BIT_CAPF])
    else $error("capture flag set without capture");
  a_flag_clear: assert property (@(posedge clk) disable iff (reset)
    s_seen_a ##1 !wr_csr ##1 (wr_csr && !req.wdata[3] && !match_a && !stby)
    |=> !csr_q[`FRTC_BIT_MAF])
    else $error("match A flag not cleared after read then zero write");
  a_noread_keep: assert property (@(posedge clk) disable iff (reset)
    (csr_q[`FRTC_BIT_WRAPF] && !seen_q[`FRTC_BIT_WRAPF] && !stby) |=> csr_q[`FRTC_BIT_WRAPF])
    else $error("wrap flag cleared without prior read");
  a_match_a_flag: assert property (@(posedge clk) disable iff (reset)
    (match_a && !stby) |=> csr_q[`FRTC_BIT_MAF])
    else $error("match A did not set flag");
  a_wrap_flag: assert property (@(posedge clk) disable iff (reset)
    (wrap && !stby) |=> (csr_q[`FRTC_BIT_WRAPF] && cnt_q == 16'h0000))
    else $error("wrap did not set flag or zero counter");
  a_clear_on_a: assert property (@(posedge clk) disable iff (reset)
    (match_a && csr_q[`FRTC_BIT_CLRA] && !stby) |=> cnt_q == 16'h0000)
    else $error("counter not cleared on match A");
  a_reserved_bits: assert property (@(posedge clk) disable iff (reset)
    (ocr_q[7:5] == 3'b111) && (ocr_q[3:2] == 2'b00) && (csr_q[6:4] == 3'b000))
    else $error("reserved bits wrong");
  a_pin_a_level: assert property (@(posedge clk) disable iff (reset)
    (match_a && !stby) |=> compare_output_pin_a == $past(ocr_q[`FRTC_BIT_LVLA]))
    else $error("pin A level wrong after match");
  a_pin_b_hold: assert property (@(posedge clk) disable iff (reset)
    !match_b |=> $stable(compare_output_pin_b))
    else $error("pin B moved without match");
  a_cnt_step: assert property (@(posedge clk) disable iff (reset)
    (tick && !cnt_wr && !stby && !(match_a && csr_q[`FRTC_BIT_CLRA]))
    |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("counter did not step");
endmodule

// *** testbench/frtc_tb_top.sv ***
`timescale 1ns/1ns
`include "frtc_cfg.svh"
module frtc_tb_top;
  logic clk;
  logic reset;
  logic stby;
  logic cap_pin;
  logic ext_pin;
  frtc_pkg::frtc_req_s req;
  logic [7:0] rdata;
  logic pin_a;
  logic pin_b;
  logic irq_c;
  logic irq_a;
  logic irq_b;
  logic irq_w;
  int miscompares;
  int checked;
  int cycles;

  // ==========================================
  // Device and clock
  frtc_top u_dut (
    .clk(clk),
    .reset(reset),
    .stby(stby),
    .req(req),
    .rdata(rdata),
    .capture_input_pin(cap_pin),
    .ext_clk_pin(ext_pin),
    .compare_output_pin_a(pin_a),
    .compare_output_pin_b(pin_b),
    .irq_capture(irq_c),
    .irq_match_a(irq_a),
    .irq_match_b(irq_b),
    .irq_wrap(irq_w)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================
  // Bus and check helpers
  task automatic end_of_test();
    $display("counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Strobe one cycle; rdata sampled just before the taking edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    #4 q = rdata;
    @(negedge clk);
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    acc(1'b0, a, 8'h00, q);
  endtask

  // High byte first so the low byte is the one latched with it
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 4'h1, v[7:0]);
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask

  // Bounded poll; each poll also arms the read-before-clear memory
  task automatic wait_flag(input int b, output logic [7:0] s);
    int n;
    n = 0;
    rd(`FRTC_ADR_CSR, s);
    while (s[b] !== 1'b1 && n < 300) begin
      rd(`FRTC_ADR_CSR, s);
      n++;
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] q;
    logic [15:0] v;
    rd(`FRTC_ADR_IER, q); chk("ier", 16'h0001, q);
    rd(`FRTC_ADR_CSR, q); chk("csr", 16'h0000, q);
    rd(`FRTC_ADR_CKE, q); chk("cke", 16'h0000, q);
    rd(`FRTC_ADR_OCR, q); chk("ocr", 16'h00e0, q);
    rd16(`FRTC_ADR_CMP_H, v); chk("cmp_a", 16'hffff, v);
    chk("pins", 16'h0000, {pin_a, pin_b});
    $display("test reset done");
  endtask

  task automatic t_fields();
    logic [7:0] q;
    wr(`FRTC_ADR_OCR, 8'h1f);
    rd(`FRTC_ADR_OCR, q); chk("ocr_fixed", 16'h00f3, q);
    wr(`FRTC_ADR_CSR, 8'hff);
    rd(`FRTC_ADR_CSR, q); chk("csr_fixed", 16'h0001, q);
    wr(`FRTC_ADR_CSR, 8'h00);
    wr(`FRTC_ADR_OCR, 8'he0);
    $display("test fields done");
  endtask

  task automatic t_match_a();
    logic [7:0] s;
    logic [15:0] c;
    wr16(`FRTC_ADR_CMP_H, 16'h0010);
    wr(`FRTC_ADR_OCR, 8'he2);
    wr(`FRTC_ADR_CSR, 8'h01);
    wait_flag(3, s); chk("flag_a", 16'h0001, s[3]);
    rd16(`FRTC_ADR_CNT_H, c); chk("cleared", 16'h0001, c <= 16'h0001);
    chk("pin_a_hi", 16'h0001, pin_a);
    // A write of one to the flag uses up the read, so the zero after it must not clear
    wr(`FRTC_ADR_CSR, 8'h09);
    wr(`FRTC_ADR_CSR, 8'h01);
    rd(`FRTC_ADR_CSR, s); chk("no_read_kept", 16'h0001, s[3]);
    wr(`FRTC_ADR_CSR, 8'h01);
    rd(`FRTC_ADR_CSR, s); chk("read_cleared", 16'h0000, s[3]);
    wr(`FRTC_ADR_OCR, 8'he0);
    chk("pin_a_hold", 16'h0001, pin_a);
    wait_flag(3, s); chk("pin_a_lo", 16'h0000, pin_a);
    $display("test match_a done");
  endtask

  task automatic t_match_b();
    logic [7:0] s;
    logic [15:0] v;
    wr(`FRTC_ADR_OCR, 8'hf1);
    wr16(`FRTC_ADR_CMP_H, 16'h0008);
    wait_flag(2, s); chk("flag_b", 16'h0001, s[2]);
    chk("pin_b_hi", 16'h0001, pin_b);
    wr(`FRTC_ADR_OCR, 8'he0);
    rd16(`FRTC_ADR_CMP_H, v); chk("cmp_a_kept", 16'h0010, v);
    $display("test match_b done");
  endtask

  task automatic t_wrap();
    logic [7:0] s;
    wr(`FRTC_ADR_CSR, 8'h00);
    wr(`FRTC_ADR_IER, 8'h8e);
    wr16(`FRTC_ADR_CNT_H, 16'hfffc);
    wait_flag(1, s); chk("flag_wrap", 16'h0001, s[1]);
    chk("irq_wrap_on", 16'h0001, irq_w);
    wr(`FRTC_ADR_IER, 8'h00);
    rd(`FRTC_ADR_IER, s); chk("ier_masked", 16'h0001, s);
    chk("irq_wrap_off", 16'h0000, irq_w);
    $display("test wrap done");
  endtask

  // Two counter samples exactly four prescaled periods apart
  task automatic t_clock();
    logic [15:0] c0;
    logic [15:0] c1;
    int div;
    for (int k = 0; k < 3; k++) begin
      div = 8 << (2 * k);
      wr(`FRTC_ADR_CKE, k[7:0]);
      rd16(`FRTC_ADR_CNT_H, c0);
      repeat (4 * div - 4) @(negedge clk);
      rd16(`FRTC_ADR_CNT_H, c1);
      chk("rate", 16'h0004, c1 - c0);
    end
    wr(`FRTC_ADR_CKE, 8'h03);
    rd16(`FRTC_ADR_CNT_H, c0);
    repeat (3) begin
      @(negedge clk) ext_pin <= 1'b1;
      repeat (8) @(negedge clk);
      ext_pin <= 1'b0;
      repeat (8) @(negedge clk);
    end
    rd16(`FRTC_ADR_CNT_H, c1);
    chk("ext_rate", 16'h0003, c1 - c0);
    $display("test clock done");
  endtask

  task automatic t_capture();
    logic [7:0] s;
    logic [15:0] v;
    logic [15:0] c;
    wr(`FRTC_ADR_CKE, 8'h00);
    wr(`FRTC_ADR_IER, 8'h8e);
    @(negedge clk) cap_pin <= 1'b1;
    repeat (10) @(negedge clk);
    rd(`FRTC_ADR_CSR, s); chk("cap_rise_ign", 16'h0000, s[7]);
    cap_pin <= 1'b0;
    repeat (10) @(negedge clk);
    rd(`FRTC_ADR_CSR, s); chk("cap_fall", 16'h0001, s[7]);
    rd16(`FRTC_ADR_CAP_H, v);
    rd16(`FRTC_ADR_CNT_H, c); chk("cap_value", 16'h0001, (c - v) <= 16'h0002);
    wr(`FRTC_ADR_CSR, 8'h00);
    wr(`FRTC_ADR_CKE, 8'h80);
    @(negedge clk) cap_pin <= 1'b1;
    repeat (10) @(negedge clk);
    rd(`FRTC_ADR_CSR, s); chk("cap_rise", 16'h0001, s[7]);
    chk("irq_cap", 16'h0002, {irq_c, irq_w});
    $display("test capture done");
  endtask

  // Standby reloads the registers but leaves the pins as they were
  task automatic t_stby();
    logic [7:0] q;
    // Drive both pins high first, so a pin reset by standby would show
    wr(`FRTC_ADR_OCR, 8'hf3);
    rd(`FRTC_ADR_CSR, q);
    wr(`FRTC_ADR_CSR, 8'h00);
    wr16(`FRTC_ADR_CNT_H, 16'h0007);
    wait_flag(3, q); chk("pins_set", 16'h0003, {pin_a, pin_b});
    chk("irq_match", 16'h0003, {irq_a, irq_b});
    @(negedge clk) stby <= 1'b1;
    @(negedge clk) stby <= 1'b0;
    rd(`FRTC_ADR_OCR, q); chk("stby_ocr", 16'h00e0, q);
    rd(`FRTC_ADR_CKE, q); chk("stby_cke", 16'h0000, q);
    rd(`FRTC_ADR_CSR, q); chk("stby_csr", 16'h0000, q);
    chk("stby_pins", 16'h0003, {pin_a, pin_b});
    chk("stby_irq", 16'h0000, {irq_c, irq_a, irq_b, irq_w});
    $display("test stby done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    reset = 1'b1;
    stby = 1'b0;
    cap_pin = 1'b0;
    ext_pin = 1'b0;
    req = '0;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_fields();
    t_match_a();
    t_match_b();
    t_wrap();
    t_clock();
    t_capture();
    t_stby();
    end_of_test();
  end
endmodule
